// [include/dpmb_pkg.sv]
/*
  Shared constants and types for the host-side controller of one port of
  an asynchronous dual-port memory with mailbox flags and token latches.
  Assumes the host clock runs at CLK_PERIOD_NS and that all timing figures
  below are met by rounding each wait up to whole cycles.
*/
package dpmb_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned LATCH_IDX_W = 3;
  localparam int unsigned LATCH_COUNT = 8;
  localparam int unsigned TIMER_W     = 8;

  localparam logic [ADDR_W-1:0] MAILBOX_ADDR_LEFT  = 13'h1FFE;
  localparam logic [ADDR_W-1:0] MAILBOX_ADDR_RIGHT = 13'h1FFF;
  localparam logic [LATCH_IDX_W-1:0] LATCH_IDX_LAST = 3'h7;

  // ----------------------------------------------------------------
  // timing, in ns and in cycles (least times, rounded up)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned T_ACCESS_NS      = 55;
  localparam int unsigned T_FLOW_NS        = 55;
  localparam int unsigned T_WPULSE_NS      = 55;
  localparam int unsigned T_RECOVER_NS     = 55;
  localparam int unsigned T_BUSY_SETTLE_NS = 55;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int unsigned CYC_SETTLE  = ns_to_cyc(T_BUSY_SETTLE_NS);
  localparam int unsigned CYC_RDHOLD  = ns_to_cyc(T_ACCESS_NS + T_FLOW_NS);
  localparam int unsigned CYC_WPULSE  = ns_to_cyc(T_WPULSE_NS);
  localparam int unsigned CYC_RECOVER = ns_to_cyc(T_RECOVER_NS);

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_MEM_RD     = 3'h0,
    OP_MEM_WR     = 3'h1,
    OP_LATCH_REQ  = 3'h2,
    OP_LATCH_REL  = 3'h3,
    OP_LATCH_RD   = 3'h4,
    OP_LATCH_INIT = 3'h5
  } dpmb_op_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ADDR  = 5'h02,
    ST_PULSE = 5'h04,
    ST_GAP   = 5'h08,
    ST_RESP  = 5'h10
  } dpmb_state_e;

  typedef struct packed {
    dpmb_state_e             state;
    logic [2:0]              op;
    logic                    latch;
    logic                    wr;
    logic                    readback;
    logic                    wbit;
    logic [LATCH_IDX_W-1:0]  idx;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       wdata;
    logic [DATA_W-1:0]       rdata;
    logic                    ce_n;
    logic                    rw_n;
    logic                    oe_n;
    logic                    token_latch_select_n;
    logic [DATA_W-1:0]       dout;
    logic                    doe;
    logic                    busy_n;
    logic                    mail_n;
    logic                    ready;
    logic                    rsp_valid;
    logic                    granted;
  } dpmb_host_s;

  localparam dpmb_host_s HOST_RESET = '{
    state:                ST_IDLE,
    op:                   3'h0,
    latch:                1'b0,
    wr:                   1'b0,
    readback:             1'b0,
    wbit:                 1'b1,
    idx:                  3'h0,
    addr:                 13'h0000,
    wdata:                8'h00,
    rdata:                8'h00,
    ce_n:                 1'b1,
    rw_n:                 1'b1,
    oe_n:                 1'b1,
    token_latch_select_n: 1'b1,
    dout:                 8'h00,
    doe:                  1'b0,
    busy_n:               1'b1,
    mail_n:               1'b1,
    ready:                1'b0,
    rsp_valid:            1'b0,
    granted:              1'b0
  };

endpackage : dpmb_pkg

// [hdl/dpmb_timer.sv]
/*
  Down-counter that times one phase of a port access.
  Assumes the caller pulses i_start only when it enters a phase and waits
  for o_done afterwards.
*/
`timescale 1ns/1ps
module dpmb_timer
  import dpmb_pkg::*;
#(
  parameter int unsigned W = TIMER_W
)(
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_clk_en,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_cycles,
  output logic              o_done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } dpmb_timer_s;

  dpmb_timer_s q;
  dpmb_timer_s d;

  always_comb
  begin
    d = q;
    if (i_start)
    begin
      d.cnt = i_cycles;
    end
    else if (q.cnt != '0)
    begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= '0;
    end
    else if (i_clk_en)
    begin
      q <= d;
    end
  end

  assign o_done = (q.cnt == '0);

endmodule : dpmb_timer

// [hdl/dpmb_host.sv]
/*
  Host-side controller for one port of an asynchronous dual-port memory
  with mailbox flags and token latches. Takes one command at a time at a
  valid/ready port and plays it out on the port pins with timed phases.
  Assumes the device pins are sampled synchronously to i_ref_clk and the
  testbench resolves the data bus from o_data_oe and the device's drive.

// Functional notes
// - Reader waits the flowthrough delay before sampling written data.
// - Master busy feeds slave busy; writes wait until busy settles.
// - Requester reads back: 0 owns, 1 means keep polling.
// - After a latch write, deselect for recovery before reading back.
// - Software writes 1 to every latch at initialisation.
*/
`timescale 1ns/1ps
module dpmb_host
  import dpmb_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_clk_en,
  // user command port
  input  wire logic                   i_cmd_valid,
  input  wire logic [2:0]             i_cmd_op,
  input  wire logic [ADDR_W-1:0]      i_cmd_addr,
  input  wire logic [DATA_W-1:0]      i_cmd_wdata,
  output logic                        o_cmd_ready,
  output logic                        o_rsp_valid,
  output logic [DATA_W-1:0]           o_rsp_rdata,
  output logic                        o_rsp_granted,
  output logic                        o_mailbox_flag_n,
  // device port pins
  output logic [ADDR_W-1:0]           o_addr,
  output logic                        o_ce_n,
  output logic                        o_rw_n,
  output logic                        o_oe_n,
  output logic                        o_token_latch_select_n,
  input  wire logic [DATA_W-1:0]      i_data,
  output logic [DATA_W-1:0]           o_data,
  output logic                        o_data_oe,
  input  wire logic                   i_contention_flag_n,
  input  wire logic                   i_mailbox_flag_n
);

  dpmb_host_s           q;
  dpmb_host_s           d;
  logic                 t_start;
  logic [TIMER_W-1:0]   t_cycles;
  logic                 t_done;

  // ----------------------------------------------------------------
  // phase timer
  // ----------------------------------------------------------------
  dpmb_timer #(
    .W (TIMER_W)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_clk_en  (i_clk_en),
    .i_start   (t_start),
    .i_cycles  (t_cycles),
    .o_done    (t_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d         = q;
    t_start   = 1'b0;
    t_cycles  = '0;
    d.rsp_valid = 1'b0;
    d.busy_n  = i_contention_flag_n;
    d.mail_n  = i_mailbox_flag_n;

    case (q.state)
      ST_IDLE:
      begin
        d.ready = 1'b1;
        if (i_cmd_valid && q.ready)
        begin
          d.ready    = 1'b0;
          d.op       = i_cmd_op;
          d.addr     = i_cmd_addr;
          d.wdata    = i_cmd_wdata;
          d.idx      = i_cmd_addr[LATCH_IDX_W-1:0];
          d.readback = 1'b0;
          d.wbit     = 1'b1;
          d.granted  = 1'b0;
          d.state    = ST_ADDR;
          case (i_cmd_op)
            OP_MEM_RD:
            begin
              d.latch = 1'b0;
              d.wr    = 1'b0;
            end
            OP_MEM_WR:
            begin
              d.latch = 1'b0;
              d.wr    = 1'b1;
            end
            OP_LATCH_REQ:
            begin
              d.latch    = 1'b1;
              d.wr       = 1'b1;
              d.wbit     = 1'b0;
              d.readback = 1'b1;
            end
            OP_LATCH_REL:
            begin
              d.latch = 1'b1;
              d.wr    = 1'b1;
            end
            OP_LATCH_RD:
            begin
              d.latch = 1'b1;
              d.wr    = 1'b0;
            end
            OP_LATCH_INIT:
            begin
              d.latch = 1'b1;
              d.wr    = 1'b1;
              d.idx   = '0;
            end
            default:
            begin
              // unknown codes are answered at once with zero data
              d.latch = 1'b0;
              d.rdata = '0;
              d.state = ST_RESP;
            end
          endcase
        end
      end

      ST_ADDR:
      begin
        // write data may only be driven while oe keeps the device quiet
        if (t_done && (q.latch || !q.wr || q.busy_n))
        begin
          t_start = 1'b1;
          d.state = ST_PULSE;
          if (q.wr)
          begin
            d.rw_n   = 1'b0;
            t_cycles = CYC_WPULSE[TIMER_W-1:0];
          end
          else
          begin
            d.oe_n   = 1'b0;
            t_cycles = CYC_RDHOLD[TIMER_W-1:0];
          end
        end
      end

      ST_PULSE:
      begin
        if (t_done)
        begin
          if (!q.wr)
          begin
            d.rdata = i_data;
          end
          // both selects high floats the port and powers it down
          d.rw_n                 = 1'b1;
          d.oe_n                 = 1'b1;
          d.ce_n                 = 1'b1;
          d.token_latch_select_n = 1'b1;
          t_start  = 1'b1;
          t_cycles = CYC_RECOVER[TIMER_W-1:0];
          d.state  = ST_GAP;
        end
      end

      ST_GAP:
      begin
        // data is held through the gap to cover hold time after rw rises
        if (t_done)
        begin
          d.doe = 1'b0;
          if (q.readback)
          begin
            d.readback = 1'b0;
            d.wr       = 1'b0;
            d.state    = ST_ADDR;
          end
          else if ((q.op == OP_LATCH_INIT) && (q.idx != LATCH_IDX_LAST))
          begin
            d.idx   = q.idx + 1'b1;
            d.state = ST_ADDR;
          end
          else
          begin
            d.state = ST_RESP;
          end
        end
      end

      ST_RESP:
      begin
        d.rsp_valid = 1'b1;
        d.granted   = q.latch && !q.rdata[0];
        d.ready     = 1'b1;
        d.state     = ST_IDLE;
      end

      default:
      begin
        d = HOST_RESET;
      end
    endcase

    // pin setup on every entry into the address phase
    if ((d.state == ST_ADDR) && (q.state != ST_ADDR))
    begin
      t_start  = 1'b1;
      t_cycles = CYC_SETTLE[TIMER_W-1:0];
      d.rw_n   = 1'b1;
      d.oe_n   = 1'b1;
      if (d.latch)
      begin
        // chip select stays high while latches are selected
        d.ce_n                 = 1'b1;
        d.token_latch_select_n = 1'b0;
        d.addr = {{(ADDR_W-LATCH_IDX_W){1'b0}}, d.idx};
        d.dout = {{(DATA_W-1){1'b0}}, d.wbit};
      end
      else
      begin
        d.ce_n                 = 1'b0;
        d.token_latch_select_n = 1'b1;
        d.dout                 = d.wdata;
      end
      d.doe = d.wr;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= HOST_RESET;
    end
    else if (i_clk_en)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign o_cmd_ready            = q.ready;
  assign o_rsp_valid            = q.rsp_valid;
  assign o_rsp_rdata            = q.rdata;
  assign o_rsp_granted          = q.granted;
  assign o_mailbox_flag_n       = q.mail_n;
  assign o_addr                 = q.addr;
  assign o_ce_n                 = q.ce_n;
  assign o_rw_n                 = q.rw_n;
  assign o_oe_n                 = q.oe_n;
  assign o_token_latch_select_n = q.token_latch_select_n;
  assign o_data                 = q.dout;
  assign o_data_oe              = q.doe;

endmodule : dpmb_host

// [tb/dpmb_monitor.sv]
/* assertions on the host controller ports
   assumes bind from tb, one clock and an async active-low reset */
`timescale 1ns/1ps
module dpmb_monitor
  import dpmb_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_resetn,
  input wire logic              i_clk_en,
  input wire logic              o_mailbox_flag_n,
  input wire logic              i_mailbox_flag_n,
  input wire logic              o_ce_n,
  input wire logic              o_rw_n,
  input wire logic              o_oe_n,
  input wire logic              o_token_latch_select_n,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic              o_data_oe,
  input wire logic              i_contention_flag_n
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_wr_pulse;
    !o_rw_n [*3] ##1 o_rw_n;
  endsequence
  sequence s_rd_pulse;
    !o_oe_n [*4] ##1 o_oe_n;
  endsequence
  property p_one_sel;
    !(!o_ce_n && !o_token_latch_select_n);
  endproperty
  a_one_sel: assert property (p_one_sel)
    else $error("both selects low");
  property p_wr_len;
    $fell(o_rw_n) |-> s_wr_pulse;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write pulse length");
  property p_rd_len;
    $fell(o_oe_n) |-> s_rd_pulse;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read pulse length");
  property p_rd_sel;
    $fell(o_oe_n) |-> o_rw_n && (o_ce_n != o_token_latch_select_n);
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("read without one select");
  property p_oe_drive;
    o_data_oe |-> o_oe_n;
  endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("host drives while output enabled");
  property p_wr_bit;
    !o_token_latch_select_n && o_data_oe |-> o_data[7:1] == 7'h00;
  endproperty
  a_wr_bit: assert property (p_wr_bit)
    else $error("latch write uses upper bits");
  property p_busy;
    $fell(o_rw_n) && !o_ce_n |-> $past(i_contention_flag_n, 2);
  endproperty
  a_busy: assert property (p_busy)
    else $error("write started while busy");
  property p_flag;
    $past(i_resetn) && $past(i_clk_en) |->
      o_mailbox_flag_n == $past(i_mailbox_flag_n);
  endproperty
  a_flag: assert property (p_flag)
    else $error("mailbox flag not forwarded");
endmodule : dpmb_monitor

// [tb/dpmb_dev_model.sv]
/* memory device seen from its left port; the right port is
   reduced to write pulses from the bench */
`timescale 1ns/1ps
module dpmb_dev_model
  import dpmb_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_ce_n,
  input  wire logic              i_rw_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_sel_n,
  input  wire logic [DATA_W-1:0] i_host_data,
  input  wire logic              i_host_oe,
  input  wire logic              i_busy_n,
  input  wire logic              i_oth_wr,
  input  wire logic              i_oth_sem,
  input  wire logic [ADDR_W-1:0] i_oth_addr,
  input  wire logic [DATA_W-1:0] i_oth_data,
  output logic      [DATA_W-1:0] o_bus,
  output logic                   o_left_flag_n,
  output logic                   o_right_flag_n,
  output logic                   o_oth_view
);
  logic [DATA_W-1:0] mem [0:8191];
  logic [1:0]        own [LATCH_COUNT];
  logic [7:0]        pend [1:2];
  logic [DATA_W-1:0] last_q;
  logic              lw_q;
  logic              lw;
  logic              rd_mem;
  logic              rd_sem;
  assign rd_mem = !i_ce_n && i_rw_n && !i_oe_n && i_sel_n;
  assign rd_sem = i_ce_n && i_rw_n && !i_oe_n && !i_sel_n;
  assign lw = i_ce_n && !i_rw_n && !i_sel_n;
  assign o_oth_view = own[i_oth_addr[2:0]] != 2'h2;
  // a released bus shows the inverse of its last value, never a stale copy
  always_comb
  begin
    if (i_host_oe)
      o_bus = i_host_data;
    else if (rd_sem)
      o_bus = {8{own[i_addr[2:0]] != 2'h1}};
    else if (rd_mem)
      o_bus = mem[i_addr];
    else
      o_bus = ~last_q;
  end
  // owner codes: 0 free, 1 left, 2 right, 3 not yet set
  task automatic upd(input logic [1:0] s, input logic [2:0] x,
                     input logic b);
    logic [1:0] t;
    t = 2'h3 - s;
    if (!b && own[x] inside {2'h0, 2'h3})
      own[x] <= s;
    else if (!b && own[x] == t)
      pend[s][x] <= 1'b1;
    else if (b && own[x] == s)
    begin
      own[x]     <= pend[t][x] ? t : 2'h0;
      pend[t][x] <= 1'b0;
    end
    else if (b && own[x] == 2'h3)
      own[x] <= 2'h0;
    if (b)
      pend[s][x] <= 1'b0;
  endtask : upd
  initial
  begin
    {o_left_flag_n, o_right_flag_n, lw_q, last_q} = 11'h600;
    pend[1] = 8'h00;
    pend[2] = 8'h00;
    for (int i = 0; i < LATCH_COUNT; i++)
      own[i] = 2'h3;
  end
  always @(posedge i_ref_clk)
  begin
    last_q <= o_bus;
    lw_q <= lw;
    if (!i_ce_n && !i_rw_n && i_sel_n && i_busy_n)
    begin
      mem[i_addr] <= o_bus;
      if (i_addr == MAILBOX_ADDR_RIGHT)
        o_right_flag_n <= 1'b0;
    end
    if (rd_mem && i_addr == MAILBOX_ADDR_LEFT)
      o_left_flag_n <= 1'b1;
    if (i_oth_wr)
    begin
      mem[i_oth_addr] <= i_oth_data;
      if (i_oth_addr == MAILBOX_ADDR_LEFT)
        o_left_flag_n <= 1'b0;
    end
    if (lw && !lw_q)
      upd(2'h1, i_addr[2:0], o_bus[0]);
    // a same-edge clash on one latch: the later call wins, one owner only
    if (i_oth_sem)
      upd(2'h2, i_oth_addr[2:0], i_oth_data[0]);
  end
endmodule : dpmb_dev_model

// [tb/tb.sv]
/* self-checking bench: host controller on the left port of the
   device model, right port played by bench pulses */
`timescale 1ns/1ps
module tb;
  import dpmb_pkg::*;
  logic i_ref_clk, i_resetn, i_clk_en, i_cmd_valid, o_cmd_ready;
  logic o_rsp_valid, o_rsp_granted, o_mailbox_flag_n, o_ce_n, o_rw_n;
  logic o_oe_n, o_token_latch_select_n, o_data_oe, i_contention_flag_n;
  logic i_mailbox_flag_n, oth_wr, oth_sem, right_flag_n, oth_view;
  logic [2:0]        i_cmd_op;
  logic [ADDR_W-1:0] i_cmd_addr, o_addr, oth_a;
  logic [DATA_W-1:0] i_cmd_wdata, o_rsp_rdata, i_data, o_data, oth_d;
  int                n_errors;
  int                n_tests;
  dpmb_host i_dut (.*);
  dpmb_dev_model i_dev (.i_ref_clk, .i_addr(o_addr), .i_ce_n(o_ce_n),
    .i_rw_n(o_rw_n), .i_oe_n(o_oe_n), .i_sel_n(o_token_latch_select_n),
    .i_host_data(o_data), .i_host_oe(o_data_oe),
    .i_busy_n(i_contention_flag_n), .i_oth_wr(oth_wr), .i_oth_sem(oth_sem),
    .i_oth_addr(oth_a), .i_oth_data(oth_d), .o_bus(i_data),
    .o_left_flag_n(i_mailbox_flag_n), .o_right_flag_n(right_flag_n),
    .o_oth_view(oth_view));
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // waits poll on falling edges; a wait that runs out ends the run
  task automatic wait_hi(input bit rsp);
    for (int k = 0; (rsp ? o_rsp_valid : o_cmd_ready) !== 1'b1; k++)
    begin
      if (k > 400)
      begin
        n_errors++;
        end_sim();
      end
      @(negedge i_ref_clk);
    end
  endtask : wait_hi
  task automatic cmd(input logic [2:0] c, input logic [12:0] ad,
                     input logic [7:0] d);
    @(negedge i_ref_clk);
    wait_hi(1'b0);
    {i_cmd_op, i_cmd_addr, i_cmd_wdata, i_cmd_valid} = {c, ad, d, 1'b1};
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b0;
    wait_hi(1'b1);
  endtask : cmd
  task automatic oth(input logic s, input logic [12:0] ad,
                     input logic [7:0] d);
    @(negedge i_ref_clk);
    {oth_wr, oth_sem, oth_a, oth_d} = {!s, s, ad, d};
    @(negedge i_ref_clk);
    {oth_wr, oth_sem} = 2'h0;
  endtask : oth
  task automatic t_init;
    cmd(OP_LATCH_INIT, 13'h0000, 8'h00);
    cmd(OP_LATCH_RD, 13'h1FF8, 8'h00);
    chk(o_rsp_rdata, 8'hFF);
    cmd(OP_LATCH_RD, 13'h0007, 8'h00);
    chk({7'h00, o_rsp_granted}, 8'h00);
  endtask : t_init
  task automatic t_mem;
    cmd(OP_MEM_WR, 13'h0123, 8'hA5);
    cmd(OP_MEM_WR, MAILBOX_ADDR_RIGHT, 8'h5A);
    chk({7'h00, right_flag_n}, 8'h00);
    cmd(OP_MEM_RD, 13'h0123, 8'h00);
    chk(o_rsp_rdata, 8'hA5);
    cmd(OP_MEM_RD, MAILBOX_ADDR_RIGHT, 8'h00);
    chk(o_rsp_rdata, 8'h5A);
  endtask : t_mem
  // an offer made while frozen must not be taken
  task automatic t_freeze;
    @(negedge i_ref_clk);
    {i_clk_en, i_cmd_op, i_cmd_addr, i_cmd_valid} =
      {1'b0, OP_MEM_RD, 13'h0123, 1'b1};
    repeat (8) @(negedge i_ref_clk);
    chk({6'h00, o_cmd_ready, o_rsp_valid}, 8'h02);
    {i_clk_en, i_cmd_valid} = 2'h2;
    cmd(OP_MEM_RD, 13'h0123, 8'h00);
    chk(o_rsp_rdata, 8'hA5);
  endtask : t_freeze
  // unknown code after a latch op: no grant may leak from the last op
  task automatic t_unk;
    cmd(3'h6, 13'h0003, 8'h00);
    chk({o_rsp_rdata[7:1], o_rsp_granted}, 8'h00);
  endtask : t_unk
  task automatic t_mbx;
    oth(1'b0, MAILBOX_ADDR_LEFT, 8'h3C);
    @(negedge i_ref_clk);
    chk({7'h00, o_mailbox_flag_n}, 8'h00);
    cmd(OP_MEM_RD, MAILBOX_ADDR_LEFT, 8'h00);
    chk(o_rsp_rdata, 8'h3C);
    @(negedge i_ref_clk);
    chk({7'h00, o_mailbox_flag_n}, 8'h01);
  endtask : t_mbx
  task automatic t_sem;
    cmd(OP_LATCH_REQ, 13'h0003, 8'h00);
    oth_a = 13'h0003;
    chk({5'h00, o_rsp_rdata[0], o_rsp_granted, oth_view}, 8'h03);
    chk(o_rsp_rdata, 8'h00);
    oth(1'b1, 13'h0003, 8'h00);
    cmd(OP_LATCH_REL, 13'h0003, 8'h01);
    chk({7'h00, oth_view}, 8'h00);
    cmd(OP_LATCH_REQ, 13'h0003, 8'h00);
    chk({7'h00, o_rsp_granted}, 8'h00);
    oth(1'b1, 13'h0003, 8'h01);
    cmd(OP_LATCH_RD, 13'h0003, 8'h00);
    chk(o_rsp_rdata, 8'h00);
    cmd(OP_LATCH_REL, 13'h0003, 8'h01);
    cmd(OP_LATCH_RD, 13'h0003, 8'h00);
    chk({o_rsp_rdata[7:1], oth_view}, 8'hFF);
  endtask : t_sem
  task automatic t_busy;
    // bench plays the master's busy output: arbitration lost for now
    i_contention_flag_n = 1'b0;
    fork
      cmd(OP_MEM_WR, 13'h0456, 8'hC3);
      begin
        repeat (30) @(negedge i_ref_clk);
        chk({7'h00, o_cmd_ready}, 8'h00);
        i_contention_flag_n = 1'b1;
      end
    join
    cmd(OP_MEM_RD, 13'h0456, 8'h00);
    chk(o_rsp_rdata, 8'hC3);
  endtask : t_busy
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    {i_resetn, i_clk_en, i_cmd_valid, i_contention_flag_n} = 4'h5;
    {i_cmd_op, i_cmd_addr, i_cmd_wdata} = 24'h000000;
    {oth_wr, oth_sem, oth_a, oth_d} = 23'h000000;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(negedge i_ref_clk);
    chk({o_cmd_ready, o_rsp_valid, o_rsp_granted, o_ce_n, o_rw_n, o_oe_n,
         o_token_latch_select_n, o_data_oe}, 8'h1E);
    i_resetn = 1'b1;
    t_init();
    t_mem();
    t_freeze();
    t_mbx();
    t_sem();
    t_unk();
    t_busy();
    end_sim();
  end
endmodule : tb
bind dpmb_host dpmb_monitor i_mon (.*);
